// ### core/sdcs_controller.sv
// sdram controller: init, refresh, self refresh, power-down and single accesses
`timescale 1ns/1ps
`default_nettype none
module sdcs_controller
  import sdcs_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_PAUSE_CYC,
  parameter int SELF_MIN_CYCLES = SELF_MIN_CYC,
  parameter int REFRESH_GAP = REFI_CYC,
  parameter int ROW_COUNT = RESET_ROWS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reqValid,
  output logic reqReady,
  input wire sdcs_req_s req,
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  input wire logic powerDownReq,
  input wire logic selfRefreshReq,
  output logic initDone,
  output logic inSelfRefresh,
  output sdcs_pins_s pins,
  output logic [DATA_W-1:0] dqOut,
  output logic dqOeN,
  input wire logic [DATA_W-1:0] dqIn
);
  // ***************************************************
  // state
  // ***************************************************
  typedef enum logic [4:0] {
    S_PAUSE, S_INIT_PRE, S_INIT_REF1, S_INIT_REF2, S_INIT_MODE, S_INIT_EXT,
    S_IDLE, S_REFRESH, S_ACTIVE, S_ACCESS, S_RD_WAIT, S_WR_RECOVER, S_PRECHARGE,
    S_PD_ENTER, S_PD, S_SR_PRE, S_SR_ENTER, S_SR, S_SR_EXIT, S_WAIT
  } sdcs_state_e;

  localparam int READ_LATENCY = 2;

  sdcs_state_e state;
  sdcs_state_e afterWait;
  sdcs_req_s held;
  logic timerLoad;
  logic [TIMER_W-1:0] timerValue;
  logic timerDone;
  logic refreshServed;
  logic refreshPending;
  logic [TIMER_W-1:0] selfTime;
  logic [TIMER_W-1:0] rowsDone;
  logic reentryOk;
  logic longSelf;
  logic [READ_LATENCY:0] rdPipe;
  logic [TIMER_W-1:0] lapse;

  sdcs_timer #(.WIDTH(TIMER_W)) waitTimer (
    .clock(clock),
    .rst(rst),
    .load(timerLoad),
    .value(timerValue),
    .done(timerDone)
  );

  sdcs_refresh_sched #(.INTERVAL(REFRESH_GAP)) refreshSched (
    .clock(clock),
    .rst(rst),
    .enable(initDone && state != S_SR),
    .served(refreshServed),
    .pending(refreshPending)
  );

  assign refreshServed = (state == S_IDLE || state == S_PD) && refreshPending
    && timerDone && state == S_IDLE;
  // ready mirrors the idle branch, so a request is never taken unseen or dropped
  assign reqReady = (state == S_IDLE) && timerDone && !refreshPending
    && (lapse != '0) && !selfRefreshReq && !powerDownReq;
  assign inSelfRefresh = (state == S_SR);

  // ***************************************************
  // sequencer
  // ***************************************************
  // one process for state, the return state, the held request and init done
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= S_PAUSE;
      afterWait <= S_IDLE;
      held <= '0;
      initDone <= 1'b0;
    end else begin
      unique case (state)
        S_PAUSE: if (timerDone) state <= S_INIT_PRE;
        S_INIT_PRE: begin
          state <= S_WAIT;
          afterWait <= S_INIT_REF1;
        end
        // refreshes first, loads later, all before any activate
        S_INIT_REF1: begin
          state <= S_WAIT;
          afterWait <= S_INIT_REF2;
        end
        S_INIT_REF2: begin
          state <= S_WAIT;
          afterWait <= S_INIT_MODE;
        end
        S_INIT_MODE: begin
          state <= S_WAIT;
          afterWait <= S_INIT_EXT;
        end
        S_INIT_EXT: begin
          state <= S_WAIT;
          afterWait <= S_IDLE;
          initDone <= 1'b1;
        end
        S_WAIT: if (timerDone) state <= afterWait;
        S_IDLE: begin
          if (!timerDone) begin
            state <= S_IDLE;
          end else if (refreshPending) begin
            state <= S_REFRESH;
          end else if (lapse == '0 && initDone) begin
            state <= S_INIT_REF1;
          end else if (selfRefreshReq && reentryOk) begin
            state <= S_SR_PRE;
          end else if (reqValid && reqReady) begin
            held <= req;
            state <= S_ACTIVE;
          end else if (powerDownReq) begin
            state <= S_PD_ENTER;
          end
        end
        S_REFRESH: begin
          state <= S_WAIT;
          afterWait <= S_IDLE;
        end
        S_ACTIVE: begin
          state <= S_WAIT;
          afterWait <= S_ACCESS;
        end
        S_ACCESS: state <= held.write ? S_WR_RECOVER : S_RD_WAIT;
        S_RD_WAIT: if (timerDone) state <= S_PRECHARGE;
        S_WR_RECOVER: if (timerDone) state <= S_PRECHARGE;
        S_PRECHARGE: begin
          state <= S_WAIT;
          afterWait <= S_IDLE;
        end
        S_PD_ENTER: state <= S_PD;
        // power-down left when asked off or a refresh is owed
        S_PD: if (!powerDownReq || refreshPending) state <= S_IDLE;
        S_SR_PRE: begin
          state <= S_WAIT;
          afterWait <= S_SR_ENTER;
        end
        S_SR_ENTER: state <= S_SR;
        S_SR: if (!selfRefreshReq) state <= S_SR_EXIT;
        S_SR_EXIT: begin
          state <= S_WAIT;
          afterWait <= S_IDLE;
        end
      endcase
    end
  end

  // wait timer loads, chosen per state
  always_comb begin
    timerLoad = 1'b0;
    timerValue = '0;
    unique case (state)
      S_INIT_PRE, S_PRECHARGE, S_SR_PRE: begin
        timerLoad = 1'b1;
        timerValue = TIMER_W'(RP_CYC - 1);
      end
      S_INIT_REF1, S_INIT_REF2, S_REFRESH: begin
        timerLoad = 1'b1;
        timerValue = TIMER_W'(RFC_CYC - 1);
      end
      S_INIT_MODE, S_INIT_EXT: begin
        timerLoad = 1'b1;
        timerValue = TIMER_W'(1);
      end
      S_ACTIVE: begin
        timerLoad = 1'b1;
        timerValue = TIMER_W'(1);
      end
      S_ACCESS: begin
        timerLoad = 1'b1;
        timerValue = held.write ? TIMER_W'(RAS_CYC > WR_CYC ? RAS_CYC - 3 : WR_CYC)
                                : TIMER_W'(RAS_CYC > READ_LATENCY ? RAS_CYC - 3 : READ_LATENCY);
      end
      S_SR_EXIT: begin
        timerLoad = 1'b1;
        timerValue = TIMER_W'(XSR_CYC - 1);
      end
      default: begin
        timerLoad = (state == S_PAUSE) && (lapse == TIMER_W'(INIT_CYCLES));
        timerValue = TIMER_W'(INIT_CYCLES);
      end
    endcase
  end

  // power-up pause is loaded once from the lapse counter's reset value
  // lapse counts down a refresh period without any refresh; zero means lost rows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lapse <= TIMER_W'(INIT_CYCLES);
    end else if (state == S_PAUSE) begin
      lapse <= TIMER_W'(SELF_MIN_CYCLES);
    end else if (state == S_REFRESH || state == S_INIT_REF2 || state == S_SR) begin
      lapse <= TIMER_W'(SELF_MIN_CYCLES);
    end else if (lapse != '0) begin
      lapse <= lapse - 1'b1;
    end
  end

  // self refresh length and rows refreshed since exit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      selfTime <= '0;
      rowsDone <= '0;
      longSelf <= 1'b0;
    end else if (state == S_SR_ENTER) begin
      selfTime <= '0;
      rowsDone <= '0;
    end else if (state == S_SR) begin
      if (selfTime != TIMER_W'(SELF_MIN_CYCLES)) selfTime <= selfTime + 1'b1;
      longSelf <= (selfTime >= TIMER_W'(SELF_MIN_CYCLES - 1));
    end else if (state == S_REFRESH && rowsDone != TIMER_W'(ROW_COUNT)) begin
      rowsDone <= rowsDone + 1'b1;
    end
  end

  // early re-entry relies on the scheduler keeping two refreshes per interval
  assign reentryOk = !longSelf ? (rowsDone == TIMER_W'(ROW_COUNT)) || !initDone
    || (selfTime == '0) : 1'b1;

  // ***************************************************
  // pins
  // ***************************************************
  // registered command, address and mask
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pins <= '{cke: 1'b1, cmd: CMD_INHIBIT, bank: 2'h0, addr: '0, mask: '1};
    end else begin
      pins.cmd <= CMD_NOP;
      pins.bank <= 2'h0;
      pins.addr <= '0;
      pins.mask <= initDone ? '0 : '1;
      pins.cke <= !(state == S_PD_ENTER || state == S_PD || state == S_SR_ENTER
        || state == S_SR) || (state == S_PD && (!powerDownReq || refreshPending));
      unique case (state)
        S_INIT_PRE, S_PRECHARGE, S_SR_PRE: begin
          pins.cmd <= CMD_PRECHARGE;
          pins.addr[ALL_BANKS_BIT] <= 1'b1;
        end
        S_INIT_REF1, S_INIT_REF2, S_REFRESH: pins.cmd <= CMD_REFRESH;
        S_SR_ENTER: pins.cmd <= CMD_REFRESH;
        S_INIT_MODE: begin
          pins.cmd <= CMD_MODE_LOAD;
          pins.addr <= MODE_VALUE;
        end
        S_INIT_EXT: begin
          pins.cmd <= CMD_MODE_LOAD;
          pins.bank <= EXT_MODE_BANK;
          pins.addr <= EXT_MODE_VALUE;
        end
        S_ACTIVE: begin
          pins.cmd <= CMD_ACTIVE;
          pins.bank <= held.bank;
          pins.addr <= held.row;
        end
        S_ACCESS: begin
          pins.cmd <= held.write ? CMD_WRITE : CMD_READ;
          pins.bank <= held.bank;
          pins.addr <= ROW_W'(held.col);
        end
        default: pins.cmd <= (state == S_SR || state == S_PD) ? CMD_INHIBIT : CMD_NOP;
      endcase
    end
  end

  // write data driven with the write command, one word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dqOut <= '0;
      dqOeN <= 1'b1;
    end else begin
      dqOut <= (state == S_ACCESS) ? held.wdata : dqOut;
      dqOeN <= !(state == S_ACCESS && held.write);
    end
  end

  // read data returns read latency cycles after the read command
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdPipe <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      rdPipe <= {rdPipe[READ_LATENCY-1:0], state == S_ACCESS && !held.write};
      rdValid <= rdPipe[READ_LATENCY];
      rdData <= rdPipe[READ_LATENCY] ? dqIn : rdData;
    end
  end
endmodule // sdcs_controller
`default_nettype wire

// ### core/sdcs_pkg.sv
// package: sdram command codes, timing constants and request carriers for the controller
package sdcs_pkg;
  // clock period in picoseconds
  localparam int CLK_PERIOD_PS = 10000;
  // printed times in their own units
  localparam int INIT_PAUSE_US = 100;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int REFRESH_CYCLE_NS = 70;
  localparam int ROW_ACTIVE_NS = 44;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int SELF_EXIT_NS = 70;
  localparam int REFRESH_INTERVAL_NS = 15625;
  localparam int SELF_MIN_MS = 64;
  localparam int SELF_EXIT_MIN_CYC = 2;
  // derived cycle counts: least times round up
  localparam int INIT_PAUSE_CYC = (INIT_PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_CYC = (WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_CYC = (REFRESH_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAS_CYC = (ROW_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC = (PRECHARGE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XSR_RAW = (SELF_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XSR_CYC = (XSR_RAW < SELF_EXIT_MIN_CYC) ? SELF_EXIT_MIN_CYC : XSR_RAW;
  // a longest time rounds down; two refreshes per interval, so one every half
  localparam int REFI_CYC = (REFRESH_INTERVAL_NS * 1000 / 2) / CLK_PERIOD_PS;
  localparam int SELF_MIN_CYC = (SELF_MIN_MS * 100000) / (CLK_PERIOD_PS / 1000) * 10;
  localparam int RESET_ROWS = 4096;
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int DATA_W = 16;
  localparam int MASK_W = 2;
  localparam int TIMER_W = 32;

  // command pins {csN, rasN, casN, weN}
  typedef logic [3:0] sdcs_cmd_t;
  localparam sdcs_cmd_t CMD_INHIBIT = 4'h8;
  localparam sdcs_cmd_t CMD_NOP = 4'h7;
  localparam sdcs_cmd_t CMD_ACTIVE = 4'h3;
  localparam sdcs_cmd_t CMD_READ = 4'h5;
  localparam sdcs_cmd_t CMD_WRITE = 4'h4;
  localparam sdcs_cmd_t CMD_PRECHARGE = 4'h2;
  localparam sdcs_cmd_t CMD_REFRESH = 4'h1;
  localparam sdcs_cmd_t CMD_MODE_LOAD = 4'h0;
  // address bit 10 selects all banks on precharge
  localparam int ALL_BANKS_BIT = 10;
  localparam logic [ROW_W-1:0] MODE_VALUE = 12'h0_020; // read latency 2, burst length 1
  localparam logic [ROW_W-1:0] EXT_MODE_VALUE = 12'h0_000;
  localparam logic [1:0] EXT_MODE_BANK = 2'h2;

  // user request carrier
  typedef struct packed {
    logic write;
    logic [1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] wdata;
  } sdcs_req_s;

  // sdram pin carrier
  typedef struct packed {
    logic cke;
    sdcs_cmd_t cmd;
    logic [1:0] bank;
    logic [ROW_W-1:0] addr;
    logic [MASK_W-1:0] mask;
  } sdcs_pins_s;
endpackage : sdcs_pkg

// ### core/sdcs_timer.sv
// down counter that reports when a programmed wait has run out
`timescale 1ns/1ps
`default_nettype none
module sdcs_timer
  import sdcs_pkg::*;
#(
  parameter int WIDTH = TIMER_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);
  logic [WIDTH-1:0] count;

  // load a count, then run down to zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0) && !load;
endmodule // sdcs_timer
`default_nettype wire

// ### core/sdcs_refresh_sched.sv
// refresh interval tracker: raises a request every half interval and counts debt
`timescale 1ns/1ps
`default_nettype none
module sdcs_refresh_sched
  import sdcs_pkg::*;
#(
  parameter int INTERVAL = REFI_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic served,
  output logic pending
);
  logic [TIMER_W-1:0] tick;
  logic [3:0] debt;
  logic due;

  assign due = enable && (tick == TIMER_W'(INTERVAL - 1));

  // interval counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick <= '0;
    end else if (!enable || due) begin
      tick <= '0;
    end else begin
      tick <= tick + 1'b1;
    end
  end

  // owed refreshes: a new tick and a service in one cycle cancel out
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      debt <= '0;
    end else if (due && !served) begin
      debt <= (debt == 4'hf) ? debt : debt + 1'b1;
    end else if (served && !due && debt != '0) begin
      debt <= debt - 1'b1;
    end
  end

  assign pending = (debt != '0);
endmodule // sdcs_refresh_sched
`default_nettype wire

// ### test/sdcs_properties.sv
// checker: command bus timing properties of the sdram controller
`timescale 1ns/1ps
`default_nettype none
module sdcs_properties
  import sdcs_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_PAUSE_CYC,
  parameter int REFRESH_GAP = REFI_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic initDone,
  input wire logic inSelfRefresh,
  input wire sdcs_pins_s pins
);
  // ********
  // helper state
  // ********
  logic quiet;
  logic autoRef;
  int cyc;
  int refCnt;
  int modeCnt;
  int gap;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // nothing executable on the bus, and a refresh with the clock enable high
  assign quiet = pins.cmd[3] || (pins.cmd == CMD_NOP);
  assign autoRef = pins.cke && (pins.cmd == CMD_REFRESH);
  // cycles since reset, init refreshes and mode loads seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc <= 0;
      refCnt <= 0;
      modeCnt <= 0;
    end else begin
      cyc <= (cyc < INIT_CYCLES) ? cyc + 1 : cyc;
      refCnt <= (autoRef && refCnt < 2) ? refCnt + 1 : refCnt;
      modeCnt <= (pins.cmd == CMD_MODE_LOAD && modeCnt < 2) ? modeCnt + 1 : modeCnt;
    end
  end
  // cycles since the last refresh while awake and initialised
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap <= 0;
    end else begin
      gap <= (initDone && !inSelfRefresh && !autoRef) ? gap + 1 : 0;
    end
  end
  // ********
  // properties
  // ********
  AST_INIT_QUIET: assert property (cyc < INIT_CYCLES |-> quiet)
    else $error("command during power-up pause");
  AST_ACT_AFTER_INIT: assert property (pins.cmd == CMD_ACTIVE |-> refCnt == 2 && modeCnt == 2)
    else $error("activate before init loads and refreshes");
  AST_INIT_MASK: assert property (!initDone |-> pins.mask == 2'h3)
    else $error("byte mask low during init");
  AST_REFRESH_QUIET: assert property (autoRef |=> quiet [*6])
    else $error("command inside refresh cycle time");
  AST_SELF_EXIT: assert property ($fell(inSelfRefresh) |-> quiet [*8])
    else $error("command too soon after self refresh exit");
  AST_WRITE_RECOVERY: assert property (pins.cmd == CMD_WRITE |=> pins.cmd != CMD_PRECHARGE)
    else $error("precharge inside write recovery");
  AST_ROW_ACTIVE: assert property (pins.cmd == CMD_ACTIVE |=> pins.cmd != CMD_PRECHARGE [*4])
    else $error("precharge inside row active time");
  AST_REFRESH_GAP: assert property (gap < 2 * REFRESH_GAP)
    else $error("refresh interval exceeded");
  AST_COL_HIGH: assert property ((pins.cmd == CMD_READ || pins.cmd == CMD_WRITE) |->
    pins.addr[ROW_W-1:COL_W] == 3'h0)
    else $error("upper column bits not zero");
  COV_WRITE: cover property (pins.cmd == CMD_WRITE);
  COV_READ: cover property (pins.cmd == CMD_READ);
  COV_SELF: cover property ($rose(inSelfRefresh));
  COV_PDOWN: cover property (!pins.cke && !inSelfRefresh);
endmodule // sdcs_properties
bind sdcs_controller sdcs_properties #(
  .INIT_CYCLES(INIT_CYCLES),
  .REFRESH_GAP(REFRESH_GAP)
) chk_u (
  .clock(clock),
  .rst(rst),
  .initDone(initDone),
  .inSelfRefresh(inSelfRefresh),
  .pins(pins)
);
`default_nettype wire

// ### test/sdcs_sdram_model.sv
// model of the memory device seen on the controller's pins
`timescale 1ns/1ps
`default_nettype none
module sdcs_sdram_model
  import sdcs_pkg::*;
(
  input wire logic clock,
  input wire sdcs_pins_s pins,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic dqOeN,
  output logic [DATA_W-1:0] dqIn,
  output int refCount
);
  logic [DATA_W-1:0] mem [int];
  logic [ROW_W-1:0] openRow [NUM_BANKS];
  logic [DATA_W-1:0] rdWord;
  logic rdDue;
  int key;
  initial begin
    dqIn = 16'h0000;
    refCount = 0;
    rdDue = 1'b0;
  end
  // decode commands; nothing is decoded while the clock enable is low
  always @(posedge clock) begin
    rdDue <= 1'b0;
    if (pins.cke && !pins.cmd[3]) begin
      key = int'({pins.bank, openRow[pins.bank], pins.addr[COL_W-1:0]});
      case (pins.cmd)
        CMD_ACTIVE: openRow[pins.bank] <= pins.addr;
        CMD_WRITE: if (!dqOeN) mem[key] = dqOut;
        CMD_READ: begin
          rdWord <= mem.exists(key) ? mem[key] : 16'h0000;
          rdDue <= 1'b1;
        end
        CMD_REFRESH: refCount <= refCount + 1;
        default: ;
      endcase
    end
    // data two edges after the read, otherwise the bus shows garbage
    dqIn <= rdDue ? rdWord : ~dqIn;
  end
endmodule // sdcs_sdram_model
`default_nettype wire

// ### test/tb_sdram_command_sequencing.sv
// testbench: random accesses, power-down and self refresh against the device model
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_sequencing
  import sdcs_pkg::*;
  ;
  localparam int SELF_N = 200;
  localparam int GAP_N = 50;
  localparam int ROWS_N = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic powerDownReq = 1'b0;
  logic selfRefreshReq = 1'b0;
  sdcs_req_s req = '0;
  logic reqReady, rdValid, initDone, inSelfRefresh, dqOeN;
  logic [DATA_W-1:0] rdData, dqOut, dqIn;
  sdcs_pins_s pins;
  int refCount;
  int error_cnt = 0;
  int n_checks = 0;
  logic [DATA_W-1:0] shadow [int];
  always #5 clock = ~clock;
  sdcs_controller #(.INIT_CYCLES(20), .SELF_MIN_CYCLES(SELF_N), .REFRESH_GAP(GAP_N),
    .ROW_COUNT(ROWS_N)) dut_u (.clock(clock), .rst(rst), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .rdValid(rdValid), .rdData(rdData),
    .powerDownReq(powerDownReq), .selfRefreshReq(selfRefreshReq), .initDone(initDone),
    .inSelfRefresh(inSelfRefresh), .pins(pins), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));
  sdcs_sdram_model mdl_u (.clock(clock), .pins(pins), .dqOut(dqOut), .dqOeN(dqOeN),
    .dqIn(dqIn), .refCount(refCount));
  // ********
  // helpers
  // ********
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic timeout(input string what);
    error_cnt++;
    $display("Error %0t: no response for %s", $time, what);
    summarize();
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  function automatic logic [DATA_W-1:0] expect_of(input int key);
    return shadow.exists(key) ? shadow[key] : 16'h0000;
  endfunction
  // hold the request until an edge takes it
  task automatic access(input logic wr, input logic [1:0] b, input logic [ROW_W-1:0] r,
    input logic [COL_W-1:0] c, input logic [DATA_W-1:0] d);
    int k;
    req = '{write: wr, bank: b, row: r, col: c, wdata: d};
    reqValid = 1'b1;
    k = 0;
    while (reqReady !== 1'b1 && k < 2000) begin
      tick();
      k++;
    end
    if (k >= 2000) timeout("request");
    tick();
    reqValid = 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] b, input logic [ROW_W-1:0] r,
    input logic [COL_W-1:0] c);
    int k;
    access(1'b0, b, r, c, 16'h0000);
    k = 0;
    while (rdValid !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
    if (k >= 50) timeout("read data");
    check(rdData, expect_of(int'({b, r, c})), "read data");
  endtask
  task automatic wr_rd(input logic [1:0] b, input logic [ROW_W-1:0] r,
    input logic [COL_W-1:0] c, input logic [DATA_W-1:0] d);
    access(1'b1, b, r, c, d);
    shadow[int'({b, r, c})] = d;
    tick(); // valid is not dropped and raised again in one step
    rd_chk(b, r, c);
  endtask
  task automatic wait_sr(input logic lvl);
    int k;
    k = 0;
    while (inSelfRefresh !== lvl && k < 2000) begin
      tick();
      k++;
    end
    if (k >= 2000) timeout("self refresh state");
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    int seedv;
    int base;
    int ckeLow;
    int k;
    seedv = $urandom(32'h5633);
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    k = 0;
    while (initDone !== 1'b1 && k < 500) begin
      tick();
      k++;
    end
    if (k >= 500) timeout("init");
    check(refCount, 2, "wake-up refreshes");
    // corner addresses, then random traffic
    wr_rd(2'h3, 12'hfff, 9'h1ff, 16'ha5a5);
    wr_rd(2'h0, 12'h000, 9'h000, 16'hffff);
    repeat (20) wr_rd(2'($urandom), ROW_W'($urandom), COL_W'($urandom), DATA_W'($urandom));
    // power-down still keeps refresh going
    base = refCount;
    ckeLow = 0;
    powerDownReq = 1'b1;
    repeat (4 * GAP_N) begin
      tick();
      ckeLow += int'(pins.cke === 1'b0);
    end
    powerDownReq = 1'b0;
    check(refCount - base >= 3, 1, "refresh in power-down");
    check(ckeLow > 0, 1, "clock enable dropped");
    // long self refresh allows at once re-entry
    selfRefreshReq = 1'b1;
    wait_sr(1'b1);
    repeat (SELF_N + 100) tick();
    selfRefreshReq = 1'b0;
    wait_sr(1'b0);
    base = refCount;
    selfRefreshReq = 1'b1;
    wait_sr(1'b1);
    check(refCount - base < ROWS_N, 1, "early re-entry");
    // short self refresh needs all rows refreshed first
    repeat (20) tick();
    selfRefreshReq = 1'b0;
    wait_sr(1'b0);
    base = refCount;
    selfRefreshReq = 1'b1;
    wait_sr(1'b1);
    check(refCount - base >= ROWS_N, 1, "re-entry after rows");
    selfRefreshReq = 1'b0;
    wait_sr(1'b0);
    rd_chk(2'h3, 12'hfff, 9'h1ff);
    summarize();
  end
endmodule // tb_sdram_command_sequencing
`default_nettype wire
